// [include/crp_pkg.sv]
package crp_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] CHARGE_RATION_CONFIG_OFS  = 8'h22;
   localparam logic [7:0] PORT1_LIMIT_BEHAVIOUR_OFS = 8'h23;
   localparam logic [7:0] PORT2_LIMIT_BEHAVIOUR_OFS = 8'h24;
   localparam logic [7:0] PRODUCT_CODE_OFS          = 8'hfd;
   localparam logic [7:0] MAKER_CODE_OFS            = 8'hfe;
   localparam logic [7:0] SILICON_REVISION_OFS      = 8'hff;

   // ==========================================================
   // Values after reset and the limit write mask
   localparam logic [7:0] CONFIG_RESET  = 8'h11;
   localparam logic [7:0] LIMIT_RESET   = 8'h96;
   localparam logic [7:0] LIMIT_WR_MASK = 8'hdf;

   // ==========================================================
   // Field positions of the ration config, per port nibble
   localparam int PORT_FIELD_STRIDE  = 4;
   localparam int RATION_ENABLE_POS  = 3;
   localparam int RATION_CLEAR_POS   = 2;
   localparam int RATION_ACTION_POS  = 0;

   // Field positions of a limit behaviour register
   localparam int MIN_BUS_VOLT_POS   = 6;
   localparam int MIN_CURRENT_POS    = 2;

   // ==========================================================
   // Threshold reached responses
   typedef enum logic [1:0] {
      CRP_ACT_REPORT     = 2'b00,
      CRP_ACT_REPORT_DIS = 2'b01,
      CRP_ACT_DIS_SLEEP  = 2'b10,
      CRP_ACT_IGNORE     = 2'b11
   } crp_action_t;

   // ==========================================================
   // Accumulator layout and timing
   localparam int CHARGE_WIDTH      = 26;
   localparam int THRESHOLD_WIDTH   = 16;
   localparam int THRESHOLD_SHIFT   = 10;
   localparam int CHARGE_PERIOD_S   = 1;
   localparam longint CLK_HZ        = 125_000_000;
   localparam longint CHARGE_PERIOD_CYCLES = CLK_HZ * CHARGE_PERIOD_S;
endpackage : crp_pkg

// [core/crp_port.sv]
`timescale 1ns/1ps
module crp_port #(
   parameter int SAMPLE_WIDTH = 16
) (
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  tick,
   input  wire logic                                  active,
   input  wire logic                                  ration_enable,
   input  wire logic                                  ration_clear,
   input  wire logic [1:0]                            ration_action,
   input  wire logic [SAMPLE_WIDTH-1:0]               current_sample,
   input  wire logic [crp_pkg::THRESHOLD_WIDTH-1:0]   threshold,
   input  wire logic                                  other_alert,
   output logic                                       quota_hit,
   output logic                                       alert_oe,
   output logic                                       disconnect_req,
   output logic                                       sleep_req,
   output logic [crp_pkg::CHARGE_WIDTH-1:0]           charge_total
);
   localparam int CW = crp_pkg::CHARGE_WIDTH;

   logic [CW-1:0] total_q;
   logic [CW:0]   sum;
   logic [CW-1:0] sum_sat;
   logic          hold_zero;
   logic          reached;
   logic          hit_q;

   // ==========================================================
   // Accumulation
   assign hold_zero = !ration_enable || ration_clear;
   assign sum       = {1'b0, total_q} + (CW+1)'(current_sample);
   // Saturation keeps a long charge from wrapping back under the threshold.
   assign sum_sat   = sum[CW] ? {CW{1'b1}} : sum[CW-1:0];
   assign reached   = sum_sat[CW-1:crp_pkg::THRESHOLD_SHIFT] >= threshold;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         total_q <= '0;
      end else if (hold_zero) begin
         total_q <= '0;
      end else if (tick && active) begin
         total_q <= sum_sat;
      end
   end

   // ==========================================================
   // Status and response
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hit_q <= 1'b0;
      end else if (hold_zero) begin
         hit_q <= 1'b0;
      end else if (tick && active && reached) begin
         hit_q <= 1'b1;
      end
   end

   assign quota_hit      = hit_q;
   assign disconnect_req = hit_q && (ration_action == crp_pkg::CRP_ACT_REPORT_DIS ||
                                     ration_action == crp_pkg::CRP_ACT_DIS_SLEEP);
   assign sleep_req      = hit_q && (ration_action == crp_pkg::CRP_ACT_DIS_SLEEP);
   assign alert_oe       = other_alert || (hit_q && (ration_action == crp_pkg::CRP_ACT_REPORT ||
                                                     ration_action == crp_pkg::CRP_ACT_REPORT_DIS));
   assign charge_total   = total_q;

   // ==========================================================
   // Checks
   // Clear zeroes both.
   clear_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      ration_clear |=> (total_q == '0) && !hit_q)
      else $error("ration clear did not zero the port");
   disabled_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      !ration_enable [*2] |=> total_q == '0 && $stable(total_q))
      else $error("disabled port still accumulates");
   hit_sets_a: assert property (@(posedge clk) disable iff (!rstn)
      (tick && active && !hold_zero && reached) |=> hit_q)
      else $error("threshold reached without status");
   no_tick_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      (!hold_zero && !(tick && active)) |=> $stable(total_q))
      else $error("total moved without a tick");
   disable_drop_a: assert property (@(posedge clk) disable iff (!rstn)
      $fell(ration_enable) && hit_q |=> !disconnect_req && !sleep_req)
      else $error("response kept after disable");
endmodule : crp_port

// [core/crp_regs.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Config bit 7 enables rationing on port 2 and bit 3 on port 1.
// - A disabled port has its charge total zeroed and takes no new samples.
// - Disabling a port that reached its threshold withdraws the response and clears its status bit.
// - While a port's clear bit (6 or 2) is set, its total is held at zero and its status bit cleared.
// - Setting the clear bit releases that port's alert unless another alert source is pending.
// - Two action bits per port select report, report and disconnect, disconnect and sleep, or ignore.
// - Limit register bits 7-6 select a minimum bus voltage of 1.50, 1.75, 2.0 or 2.25 V.
// - Limit register bits 4-2 select a minimum current of 100, 530, 960, 1280, 1600 or 2130 mA.
// - The limit settings feed whichever current limiting mode, trip or constant current, is active.
// - The limit registers are not kept through sleep and come back at reset values on wake.
// - Product code at FDh and maker code at FEh are fixed read-only bytes.
// - The revision code at FFh is a fixed read-only byte.
// - While active, each port's total is updated once per second and compared with its threshold.
// - A total at or above threshold sets the status bit and starts the selected response.
module crp_regs #(
   parameter int         SAMPLE_WIDTH = 16,
   parameter longint     TICK_CYCLES  = crp_pkg::CHARGE_PERIOD_CYCLES,
   // Identity values are arbitrary.
   parameter logic [7:0] PRODUCT_CODE = 8'h5a,
   parameter logic [7:0] MAKER_CODE   = 8'h3c,
   parameter logic [7:0] REVISION     = 8'h01
) (
   input  wire logic                                clk,
   input  wire logic                                rstn,
   input  wire logic [7:0]                          reg_addr,
   input  wire logic [7:0]                          reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output logic [7:0]                               reg_rdata,
   input  wire logic                                device_active,
   input  wire logic                                device_sleep,
   input  wire logic                                limit_mode_cc,
   input  wire logic [SAMPLE_WIDTH-1:0]             port1_current,
   input  wire logic [SAMPLE_WIDTH-1:0]             port2_current,
   input  wire logic [crp_pkg::THRESHOLD_WIDTH-1:0] port1_threshold,
   input  wire logic [crp_pkg::THRESHOLD_WIDTH-1:0] port2_threshold,
   input  wire logic                                port1_other_alert,
   input  wire logic                                port2_other_alert,
   output logic                                     port1_quota_hit,
   output logic                                     port2_quota_hit,
   output logic                                     port1_alert_n_out,
   output logic                                     port1_alert_n_oe,
   output logic                                     port2_alert_n_out,
   output logic                                     port2_alert_n_oe,
   output logic                                     port1_disconnect_req,
   output logic                                     port2_disconnect_req,
   output logic                                     sleep_req,
   output logic [crp_pkg::CHARGE_WIDTH-1:0]         port1_charge_total,
   output logic [crp_pkg::CHARGE_WIDTH-1:0]         port2_charge_total,
   output logic [1:0]                               port1_min_bus_volt_sel,
   output logic [1:0]                               port2_min_bus_volt_sel,
   output logic [2:0]                               port1_min_current_sel,
   output logic [2:0]                               port2_min_current_sel,
   output logic [11:0]                              port1_min_bus_voltage,
   output logic [11:0]                              port2_min_bus_voltage,
   output logic [11:0]                              port1_trip_min_current,
   output logic [11:0]                              port2_trip_min_current,
   output logic [11:0]                              port1_cc_min_current,
   output logic [11:0]                              port2_cc_min_current
);
   localparam int TW = $clog2(TICK_CYCLES);

   logic [7:0]    config_q;
   logic [7:0]    limit_q [2];
   logic [7:0]    rdata_q;
   logic [TW-1:0] tick_cnt_q;
   logic          tick;
   logic [1:0]    hit;
   logic [1:0]    alert_oe;
   logic [1:0]    dis_req;
   logic [1:0]    slp_req;
   logic [11:0]   volt_q [2];
   logic [11:0]   curr_q [2];
   logic [crp_pkg::CHARGE_WIDTH-1:0] total [2];
   logic [SAMPLE_WIDTH-1:0]          sample [2];
   logic [crp_pkg::THRESHOLD_WIDTH-1:0] thresh [2];
   logic [1:0]    other_alert;

   // ==========================================================
   // Lookup of analog settings
   function automatic logic [11:0] volt_mv(input logic [1:0] sel);
      case (sel)
         2'b00:   volt_mv = 12'h05dc;
         2'b01:   volt_mv = 12'h06d6;
         2'b10:   volt_mv = 12'h07d0;
         default: volt_mv = 12'h08ca;
      endcase
   endfunction : volt_mv

   // Undefined codes map to the lowest current, which is the safe side for a limiter.
   function automatic logic [11:0] curr_ma(input logic [2:0] sel);
      case (sel)
         3'b000:  curr_ma = 12'h0064;
         3'b001:  curr_ma = 12'h0212;
         3'b010:  curr_ma = 12'h03c0;
         3'b011:  curr_ma = 12'h0500;
         3'b100:  curr_ma = 12'h0640;
         3'b101:  curr_ma = 12'h0852;
         default: curr_ma = 12'h0064;
      endcase
   endfunction : curr_ma

   // ==========================================================
   // One second divider
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_q <= '0;
      end else if (tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + TW'(1);
      end
   end

   assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

   // ==========================================================
   // Ration config register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         config_q <= crp_pkg::CONFIG_RESET;
      end else if (reg_wr && reg_addr == crp_pkg::CHARGE_RATION_CONFIG_OFS) begin
         config_q <= reg_wdata;
      end
   end

   // ==========================================================
   // Limit behaviour registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         limit_q[0] <= crp_pkg::LIMIT_RESET;
         limit_q[1] <= crp_pkg::LIMIT_RESET;
      end else if (device_sleep) begin
         limit_q[0] <= crp_pkg::LIMIT_RESET;
         limit_q[1] <= crp_pkg::LIMIT_RESET;
      end else if (reg_wr && reg_addr == crp_pkg::PORT1_LIMIT_BEHAVIOUR_OFS) begin
         // Bit 5 is unimplemented and reads zero.
         limit_q[0] <= reg_wdata & crp_pkg::LIMIT_WR_MASK;
      end else if (reg_wr && reg_addr == crp_pkg::PORT2_LIMIT_BEHAVIOUR_OFS) begin
         limit_q[1] <= reg_wdata & crp_pkg::LIMIT_WR_MASK;
      end
   end

   // ==========================================================
   // Read port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            crp_pkg::CHARGE_RATION_CONFIG_OFS:  rdata_q <= config_q;
            crp_pkg::PORT1_LIMIT_BEHAVIOUR_OFS: rdata_q <= limit_q[0];
            crp_pkg::PORT2_LIMIT_BEHAVIOUR_OFS: rdata_q <= limit_q[1];
            crp_pkg::PRODUCT_CODE_OFS:          rdata_q <= PRODUCT_CODE;
            crp_pkg::MAKER_CODE_OFS:            rdata_q <= MAKER_CODE;
            crp_pkg::SILICON_REVISION_OFS:      rdata_q <= REVISION;
            default:                            rdata_q <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_q;

   // ==========================================================
   // Ports
   assign sample[0]      = port1_current;
   assign sample[1]      = port2_current;
   assign thresh[0]      = port1_threshold;
   assign thresh[1]      = port2_threshold;
   assign other_alert[0] = port1_other_alert;
   assign other_alert[1] = port2_other_alert;

   for (genvar p = 0; p < 2; p++) begin : g_port
      localparam int B = p * crp_pkg::PORT_FIELD_STRIDE;

      // Runs only with clear at zero.
      crp_port #(
         .SAMPLE_WIDTH (SAMPLE_WIDTH)
      ) u_port (
         .clk            (clk),
         .rstn           (rstn),
         .tick           (tick),
         .active         (device_active),
         .ration_enable  (config_q[B + crp_pkg::RATION_ENABLE_POS]),
         .ration_clear   (config_q[B + crp_pkg::RATION_CLEAR_POS]),
         .ration_action  (config_q[B + crp_pkg::RATION_ACTION_POS +: 2]),
         .current_sample (sample[p]),
         .threshold      (thresh[p]),
         .other_alert    (other_alert[p]),
         .quota_hit      (hit[p]),
         .alert_oe       (alert_oe[p]),
         .disconnect_req (dis_req[p]),
         .sleep_req      (slp_req[p]),
         .charge_total   (total[p])
      );

      // Both limiting modes read the same registered settings.
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            volt_q[p] <= 12'h0000;
            curr_q[p] <= 12'h0000;
         end else begin
            volt_q[p] <= volt_mv(limit_q[p][crp_pkg::MIN_BUS_VOLT_POS +: 2]);
            curr_q[p] <= curr_ma(limit_q[p][crp_pkg::MIN_CURRENT_POS +: 3]);
         end
      end
   end

   assign port1_quota_hit        = hit[0];
   assign port2_quota_hit        = hit[1];
   assign port1_alert_n_out      = 1'b0;
   assign port2_alert_n_out      = 1'b0;
   assign port1_alert_n_oe       = alert_oe[0];
   assign port2_alert_n_oe       = alert_oe[1];
   assign port1_disconnect_req   = dis_req[0];
   assign port2_disconnect_req   = dis_req[1];
   assign sleep_req              = |slp_req;
   assign port1_charge_total     = total[0];
   assign port2_charge_total     = total[1];
   assign port1_min_bus_volt_sel = limit_q[0][crp_pkg::MIN_BUS_VOLT_POS +: 2];
   assign port2_min_bus_volt_sel = limit_q[1][crp_pkg::MIN_BUS_VOLT_POS +: 2];
   assign port1_min_current_sel  = limit_q[0][crp_pkg::MIN_CURRENT_POS +: 3];
   assign port2_min_current_sel  = limit_q[1][crp_pkg::MIN_CURRENT_POS +: 3];
   assign port1_min_bus_voltage  = volt_q[0];
   assign port2_min_bus_voltage  = volt_q[1];
   assign port1_trip_min_current = limit_mode_cc ? 12'h0000 : curr_q[0];
   assign port2_trip_min_current = limit_mode_cc ? 12'h0000 : curr_q[1];
   assign port1_cc_min_current   = limit_mode_cc ? curr_q[0] : 12'h0000;
   assign port2_cc_min_current   = limit_mode_cc ? curr_q[1] : 12'h0000;

   // ==========================================================
   // Checks
   // Product code read.
   product_read_a: assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && reg_addr == crp_pkg::PRODUCT_CODE_OFS |=> reg_rdata == PRODUCT_CODE)
      else $error("product code read wrong");
   revision_read_a: assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && reg_addr == crp_pkg::SILICON_REVISION_OFS |=> reg_rdata == REVISION)
      else $error("revision read wrong");
   id_write_a: assert property (@(posedge clk) disable iff (!rstn)
      reg_wr && reg_addr >= crp_pkg::PRODUCT_CODE_OFS |=> $stable(config_q) && $stable(limit_q[0])
         && $stable(limit_q[1]))
      else $error("identity write had an effect");
   sleep_restore_a: assert property (@(posedge clk) disable iff (!rstn)
      device_sleep |=> limit_q[0] == crp_pkg::LIMIT_RESET && limit_q[1] == crp_pkg::LIMIT_RESET)
      else $error("limit register kept through sleep");
   volt_map_a: assert property (@(posedge clk) disable iff (!rstn)
      $stable(limit_q[0]) && limit_q[0][7:6] == 2'b11 |=> port1_min_bus_voltage == 12'h08ca)
      else $error("bus voltage lookup wrong");
   enable_write_a: assert property (@(posedge clk) disable iff (!rstn)
      reg_wr && reg_addr == crp_pkg::CHARGE_RATION_CONFIG_OFS |=> config_q[7] == $past(reg_wdata[7]))
      else $error("enable bit not written");

   tick_seen_c:  cover property (@(posedge clk) disable iff (!rstn) tick && device_active);
   hit_seen_c:   cover property (@(posedge clk) disable iff (!rstn) $rose(port1_quota_hit));
   sleep_seen_c: cover property (@(posedge clk) disable iff (!rstn) $rose(sleep_req));
endmodule : crp_regs

// [sim/crp_host_model.sv]
`timescale 1ns/1ps
// ==========================================
// Register host model
module crp_host_model (
   input  wire logic       clk,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= (a == 8'h23 || a == 8'h24) ? {d[7:2], 2'b10} : d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // The idle bus shows inverted values so a stale address never looks valid.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : crp_host_model

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
   // Identity values are arbitrary.
   localparam logic [7:0] PROD = 8'h6b;
   localparam logic [7:0] MAKR = 8'h2e;
   localparam logic [7:0] REV  = 8'h07;
   logic clk, rstn, wr, rd, active, slp, cc, oth1, oth2;
   logic [7:0] addr, wdata, rdata, r;
   logic [15:0] cur, thr;
   logic hit1, hit2, oe1, oe2, dis1, dis2, sreq, on1, on2;
   logic [25:0] tot1, tot2;
   logic [1:0] vs1, vs2;
   logic [2:0] cs1, cs2;
   logic [11:0] mv1, mv2, tc1, tc2, cc1, cc2;
   int errors, checks_done;
   logic [11:0] mv_tab[4] = '{12'h5dc, 12'h6d6, 12'h7d0, 12'h8ca};
   logic [11:0] cu_tab[8] = '{12'h064, 12'h212, 12'h3c0, 12'h500, 12'h640, 12'h852, 12'h064, 12'h064};

   always #4 clk = ~clk;

   crp_host_model host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata));
   crp_regs #(.TICK_CYCLES(16), .PRODUCT_CODE(PROD), .MAKER_CODE(MAKR), .REVISION(REV)) dut (
      .clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .device_active(active), .device_sleep(slp), .limit_mode_cc(cc),
      .port1_current(cur), .port2_current(cur), .port1_threshold(thr), .port2_threshold(thr),
      .port1_other_alert(oth1), .port2_other_alert(oth2), .port1_quota_hit(hit1),
      .port2_quota_hit(hit2), .port1_alert_n_out(on1), .port1_alert_n_oe(oe1), .port2_alert_n_out(on2),
      .port2_alert_n_oe(oe2), .port1_disconnect_req(dis1), .port2_disconnect_req(dis2),
      .sleep_req(sreq), .port1_charge_total(tot1), .port2_charge_total(tot2),
      .port1_min_bus_volt_sel(vs1), .port2_min_bus_volt_sel(vs2), .port1_min_current_sel(cs1),
      .port2_min_current_sel(cs2), .port1_min_bus_voltage(mv1), .port2_min_bus_voltage(mv2),
      .port1_trip_min_current(tc1), .port2_trip_min_current(tc2), .port1_cc_min_current(cc1),
      .port2_cc_min_current(cc2));

   // ==========================================
   // Checking and closing
   task automatic check(input string n, input logic [25:0] s, input logic [25:0] e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // ==========================================
   // Scenarios
   task automatic t_reset();
      logic [7:0] ad[7] = '{8'h22, 8'h23, 8'h24, 8'hfd, 8'hfe, 8'hff, 8'h30};
      logic [7:0] ex[7] = '{8'h11, 8'h96, 8'h96, PROD, MAKR, REV, 8'h00};
      host.wr(8'hfd, 8'h00);
      host.wr(8'hfe, 8'h00);
      host.wr(8'hff, 8'h00);
      for (int i = 0; i < 7; i++) begin
         host.rd(ad[i], r);
         check("reset read", r, ex[i]);
      end
      check("alert pins", {on1, on2}, 2'b00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_limit();
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         cc <= i[0];
         d = {i[1:0], 1'b0, i[2:0], 2'b10};
         host.wr(8'h23, d);
         host.wr(8'h24, d);
         host.rd(8'h23, r);
         check("limit read", r, d);
         check("volt sel", vs2, i[1:0]);
         check("volt sel1", vs1, i[1:0]);
         check("cur sel", cs1, i[2:0]);
         check("cur sel2", cs2, i[2:0]);
         check("min volt", mv1, mv_tab[i[1:0]]);
         check("min volt2", mv2, mv_tab[i[1:0]]);
         check("trip cur", tc1, i[0] ? 12'h000 : cu_tab[i]);
         check("trip cur2", tc2, i[0] ? 12'h000 : cu_tab[i]);
         check("cc cur", cc2, i[0] ? cu_tab[i] : 12'h000);
         check("cc cur1", cc1, i[0] ? cu_tab[i] : 12'h000);
      end
      $display("test limit done");
   endtask : t_limit

   task automatic t_sleep();
      host.wr(8'h24, 8'h5a);
      @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      host.rd(8'h24, r);
      check("limit after sleep", r, 8'h96);
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_ration();
      int n;
      logic [1:0] a;
      for (int i = 0; i < 4; i++) begin
         a = i[1:0];
         @(posedge clk);
         oth2 <= a[0];
         host.wr(8'h22, {2'b10, a, 2'b10, a});
         for (n = 0; n < 100 && hit1 !== 1'b1; n++) begin
            @(posedge clk);
            #1;
         end
         if (n == 100) begin
            errors++;
            end_sim();
         end
         check("total at hit", tot1, 26'h000_0800);
         check("port2 hit", hit2, 1'b1);
         check("alert", oe1, a < 2);
         check("disconnect", dis1, a == 1 || a == 2);
         check("sleep req", sreq, a == 2);
         // Odd actions use the clear bit with the enable kept, even ones drop the enable.
         host.wr(8'h22, a[0] ? {2'b11, a, 2'b11, a} : {2'b00, a, 2'b00, a});
         repeat (20) @(posedge clk);
         #1;
         check("status", hit1, 1'b0);
         check("total1", tot1, 26'h000_0000);
         check("total2", tot2, 26'h000_0000);
         check("response", dis2, 1'b0);
         check("alert1", oe1, 1'b0);
         check("alert2", oe2, a[0]);
      end
      $display("test ration done");
   endtask : t_ration

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      active = 1'b1;
      slp = 1'b0;
      cc = 1'b0;
      oth1 = 1'b0;
      oth2 = 1'b0;
      cur = 16'h0400;
      thr = 16'h0002;
      errors = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_limit();
      t_sleep();
      t_ration();
      end_sim();
   end
endmodule : tb
